// File: hdl/mrs_sampler.sv
// Summary of operation
// RULE_01: parity flag clears when shaped A equals shaped B's new level at its edge.
// RULE_02: parity flag sets when shaped A differs from shaped B's new level at its edge.
// RULE_03: level flags and parity flag held cleared while timer mode is selected.
// RULE_04: mode bit at zero runs the interval counter as a plain 8-bit timer.
// RULE_05: in timer mode both sampling clocks toggle on every compare match.
// RULE_06: sampling clock pulse width comes from the two-bit width select field.
// RULE_07: sensor inputs latch on the falling edge of the sampling clock.
// RULE_08: edge interrupt on both edges of shaped B, flags updated together.
// RULE_09: phase detector stays idle in timer mode.
// RULE_10: each sampling clock drives its pin only while its enable bit is set.
`default_nettype none
module mrs_sampler
#(
    parameter int PW_LONG_CYC = mrs_pkg::PW_SEL01_CYC
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire mrs_pkg::mrs_axi_req_t s_axi_req,
    output var mrs_pkg::mrs_axi_rsp_t s_axi_rsp,
    input wire logic sensor_input_a,
    input wire logic sensor_input_b,
    output logic sample_clock_out_a,
    output logic sample_clock_out_a_oe,
    output logic sample_clock_out_b,
    output logic sample_clock_out_b_oe,
    output logic compare_match_irq,
    output logic edge_detect_irq
);
    import mrs_pkg::*;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] sampling_ctrl_ff;
    logic [7:0] counter_ctrl_reg_ff;
    logic [7:0] compare_value_ff;
    logic [7:0] interval_counter_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [ADDR_W-1:0] waddr_ff;
    logic [7:0] wdata_ff;
    logic wstrb0_ff;
    mrs_axi_rsp_t rsp_ff;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire logic aw_take = s_axi_req.awvalid & rsp_ff.awready;
    wire logic w_take = s_axi_req.wvalid & rsp_ff.wready;
    wire logic aw_have = aw_got_ff | aw_take;
    wire logic w_have = w_got_ff | w_take;
    wire logic wr_fire = aw_have & w_have & ~rsp_ff.bvalid;
    wire logic [ADDR_W-1:0] wr_addr = aw_got_ff ? waddr_ff : s_axi_req.awaddr;
    wire logic [7:0] wr_data = w_got_ff ? wdata_ff : s_axi_req.wdata[7:0];
    wire logic wr_lane0 = w_got_ff ? wstrb0_ff : s_axi_req.wstrb[0];
    wire logic wr_samp = wr_fire & wr_lane0 & (wr_addr == OFS_SAMPLING_CTRL);
    wire logic wr_cctl = wr_fire & wr_lane0 & (wr_addr == OFS_COUNTER_CTRL);
    wire logic wr_cmp = wr_fire & wr_lane0 & (wr_addr == OFS_COMPARE);
    wire logic wr_ok = (wr_addr == OFS_SAMPLING_CTRL) | (wr_addr == OFS_COUNTER_CTRL)
                     | (wr_addr == OFS_COMPARE) | (wr_addr == OFS_COUNTER);
    wire logic rd_take = s_axi_req.arvalid & rsp_ff.arready;
    wire logic rd_ok = (s_axi_req.araddr == OFS_SAMPLING_CTRL)
                     | (s_axi_req.araddr == OFS_COUNTER_CTRL)
                     | (s_axi_req.araddr == OFS_COMPARE)
                     | (s_axi_req.araddr == OFS_COUNTER);
    wire logic [7:0] rd_byte =
        (s_axi_req.araddr == OFS_SAMPLING_CTRL) ? sampling_ctrl_ff :
        (s_axi_req.araddr == OFS_COUNTER_CTRL) ? counter_ctrl_reg_ff :
        (s_axi_req.araddr == OFS_COMPARE) ? compare_value_ff :
        (s_axi_req.araddr == OFS_COUNTER) ? interval_counter_ff : 8'h00;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            waddr_ff <= '0;
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
            rsp_ff <= '0;
        end
        else
        begin
            aw_got_ff <= aw_have & ~wr_fire;
            w_got_ff <= w_have & ~wr_fire;
            if (aw_take)
                waddr_ff <= s_axi_req.awaddr;
            if (w_take)
            begin
                wdata_ff <= s_axi_req.wdata[7:0];
                wstrb0_ff <= s_axi_req.wstrb[0];
            end
            rsp_ff.awready <= ~aw_have & ~rsp_ff.bvalid;
            rsp_ff.wready <= ~w_have & ~rsp_ff.bvalid;
            if (wr_fire)
            begin
                rsp_ff.bvalid <= 1'b1;
                rsp_ff.bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                rsp_ff.awready <= 1'b0;
                rsp_ff.wready <= 1'b0;
            end
            else if (rsp_ff.bvalid & s_axi_req.bready)
                rsp_ff.bvalid <= 1'b0;
            rsp_ff.arready <= ~rsp_ff.rvalid & ~rd_take;
            if (rd_take)
            begin
                rsp_ff.rvalid <= 1'b1;
                rsp_ff.rdata <= {24'h000000, rd_byte};
                rsp_ff.rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (rsp_ff.rvalid & s_axi_req.rready)
                rsp_ff.rvalid <= 1'b0;
        end
    end

    assign s_axi_rsp = rsp_ff;

    // ----------------------------------------------------------------
    // count clock selection
    // ----------------------------------------------------------------
    logic [15:0] tick_cnt_ff;
    logic [15:0] fxt2_cnt_ff;
    logic [6:0] div_cnt_ff;
    wire logic run = counter_ctrl_reg_ff[BIT_COUNT_EN];
    wire logic sampling_mode = counter_ctrl_reg_ff[BIT_MODE_SEL];
    // timer mode counts from the write itself, so flags never outlive the mode bit
    wire logic mode_off = ~sampling_mode | (wr_cctl & ~wr_data[BIT_MODE_SEL]); // RULE_03
    wire logic [1:0] clk_sel = {counter_ctrl_reg_ff[BIT_CLK_SEL_HI],
                                counter_ctrl_reg_ff[BIT_CLK_SEL_LO]};
    wire logic sub_tick = (tick_cnt_ff == 16'(SUB_CLK1_CYC - 1));
    wire logic fxt2_tick = (fxt2_cnt_ff == 16'(SUB_CLK2_CYC - 1));
    wire logic count_tick =
        (clk_sel == 2'h0) ? sub_tick :
        (clk_sel == 2'h1) ? sub_tick & (div_cnt_ff[2:0] == 3'(DIV8_MASK)) :
        (clk_sel == 2'h2) ? sub_tick & (div_cnt_ff == 7'(DIV128_MASK)) : fxt2_tick;
    wire logic match = run & count_tick & (interval_counter_ff == compare_value_ff); // RULE_05

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tick_cnt_ff <= 16'h0000;
            fxt2_cnt_ff <= 16'h0000;
            div_cnt_ff <= 7'h00;
            interval_counter_ff <= 8'h00;
            compare_match_irq <= 1'b0;
        end
        else
        begin
            tick_cnt_ff <= sub_tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
            fxt2_cnt_ff <= fxt2_tick ? 16'h0000 : fxt2_cnt_ff + 16'h0001;
            if (sub_tick)
                div_cnt_ff <= div_cnt_ff + 7'h01;
            if (!run)
                interval_counter_ff <= 8'h00;
            else if (match)
                interval_counter_ff <= 8'h00; // RULE_04
            else if (count_tick)
                interval_counter_ff <= interval_counter_ff + 8'h01;
            compare_match_irq <= match;
        end
    end

    // ----------------------------------------------------------------
    // sampling clock outputs
    // ----------------------------------------------------------------
    logic [19:0] pulse_cnt_ff;
    logic shaped_a_ff;
    logic shaped_b_ff;
    wire logic [1:0] pw_sel = {sampling_ctrl_ff[BIT_PW_HI], sampling_ctrl_ff[BIT_PW_LO]};
    wire logic [19:0] pw_cyc = // RULE_06
        (pw_sel == 2'h0) ? 20'(PW_SEL00_CYC) :
        (pw_sel == 2'h1) ? 20'(PW_LONG_CYC) :
        (pw_sel == 2'h2) ? 20'(PW_SEL10_CYC) : 20'(PW_SEL11_CYC);
    wire logic pulse_end = sampling_mode & (pulse_cnt_ff == 20'h00001);
    wire logic b_edge = pulse_end & (sensor_input_b != shaped_b_ff);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sample_clock_out_a <= 1'b0;
            sample_clock_out_b <= 1'b0;
            sample_clock_out_a_oe <= 1'b0;
            sample_clock_out_b_oe <= 1'b0;
            pulse_cnt_ff <= 20'h00000;
            shaped_a_ff <= 1'b0;
            shaped_b_ff <= 1'b0;
        end
        else
        begin
            sample_clock_out_a_oe <= sampling_ctrl_ff[BIT_OUT_A_EN]; // RULE_10
            sample_clock_out_b_oe <= sampling_ctrl_ff[BIT_OUT_B_EN]; // RULE_10
            if (!sampling_mode)
            begin
                pulse_cnt_ff <= 20'h00000;
                if (match)
                begin
                    sample_clock_out_a <= ~sample_clock_out_a; // RULE_05
                    sample_clock_out_b <= ~sample_clock_out_b; // RULE_05
                end
            end
            else if (match)
            begin
                pulse_cnt_ff <= pw_cyc; // RULE_06
                sample_clock_out_a <= 1'b1;
                sample_clock_out_b <= 1'b1;
            end
            else if (pulse_cnt_ff != 20'h00000)
            begin
                pulse_cnt_ff <= pulse_cnt_ff - 20'h00001;
                if (pulse_end)
                begin
                    sample_clock_out_a <= 1'b0;
                    sample_clock_out_b <= 1'b0;
                    shaped_a_ff <= sensor_input_a; // RULE_07
                    shaped_b_ff <= sensor_input_b; // RULE_07
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // phase detector
    // ----------------------------------------------------------------
    logic [7:0] edge_dly_ff;
    logic cap_a_ff;
    logic cap_b_ff;
    wire logic dly_done = (edge_dly_ff == 8'h01);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            edge_dly_ff <= 8'h00;
            cap_a_ff <= 1'b0;
            cap_b_ff <= 1'b0;
            edge_detect_irq <= 1'b0;
        end
        else if (mode_off)
        begin
            edge_dly_ff <= 8'h00; // RULE_09
            edge_detect_irq <= 1'b0; // RULE_09
        end
        else
        begin
            if (b_edge)
            begin
                edge_dly_ff <= 8'(EDGE_DELAY_CYC); // RULE_08
                cap_a_ff <= sensor_input_a;
                cap_b_ff <= sensor_input_b;
            end
            else if (edge_dly_ff != 8'h00)
                edge_dly_ff <= edge_dly_ff - 8'h01;
            edge_detect_irq <= dly_done & ~b_edge; // RULE_08
        end
    end

    // ----------------------------------------------------------------
    // control register writes and status flags
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sampling_ctrl_ff <= SAMPLING_CTRL_RESET;
            counter_ctrl_reg_ff <= COUNTER_CTRL_RESET;
            compare_value_ff <= COMPARE_RESET;
        end
        else
        begin
            if (wr_cctl)
                counter_ctrl_reg_ff <= wr_data & COUNTER_CTRL_WMASK;
            if (wr_cmp)
                compare_value_ff <= wr_data;
            if (wr_samp)
                sampling_ctrl_ff[3:0] <= wr_data[3:0] & SAMPLING_CTRL_WMASK[3:0];
            if (mode_off)
                sampling_ctrl_ff[7:5] <= 3'h0; // RULE_03
            else if (dly_done & ~b_edge)
            begin
                sampling_ctrl_ff[BIT_IN_B_LEVEL] <= cap_b_ff; // RULE_08
                sampling_ctrl_ff[BIT_IN_A_LEVEL] <= cap_a_ff; // RULE_08
                sampling_ctrl_ff[BIT_PARITY] <= cap_a_ff ^ cap_b_ff; // RULE_01 RULE_02
            end
            sampling_ctrl_ff[4] <= 1'b0;
        end
    end

endmodule : mrs_sampler
`default_nettype wire

// File: hdl/mrs_pkg.sv
`default_nettype none
package mrs_pkg;

    // ----------------------------------------------------------------
    // bus shape
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic [2:0] awprot;
        logic wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic [2:0] arprot;
        logic rready;
    } mrs_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } mrs_axi_rsp_t;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_SAMPLING_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_COUNTER_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_COMPARE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_COUNTER = 8'h0C;

    // sensor_sampling_control fields
    localparam int BIT_IN_B_LEVEL = 7;
    localparam int BIT_IN_A_LEVEL = 6;
    localparam int BIT_PARITY = 5;
    localparam int BIT_PW_HI = 3;
    localparam int BIT_PW_LO = 2;
    localparam int BIT_OUT_B_EN = 1;
    localparam int BIT_OUT_A_EN = 0;
    localparam logic [7:0] SAMPLING_CTRL_WMASK = 8'h0F;
    localparam logic [7:0] SAMPLING_CTRL_RESET = 8'h00;

    // counter_control_reg fields
    localparam int BIT_COUNT_EN = 7;
    localparam int BIT_MODE_SEL = 6;
    localparam int BIT_CLK_SEL_HI = 1;
    localparam int BIT_CLK_SEL_LO = 0;
    localparam logic [7:0] COUNTER_CTRL_WMASK = 8'hC3;
    localparam logic [7:0] COUNTER_CTRL_RESET = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'hFF;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int SUB_CLK1_PERIOD_NS = 30518;
    localparam int SUB_CLK2_DIV16_NS = 3250;
    localparam int PW_SEL00_NS = 15259;
    localparam int PW_SEL01_NS = 976563;
    localparam int PW_SEL10_NS = 61035;
    localparam int PW_SEL11_NS = 30518;
    localparam int EDGE_DELAY_NS = 15000;

    localparam int SUB_CLK1_CYC = SUB_CLK1_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SUB_CLK2_CYC = SUB_CLK2_DIV16_NS / CLK_PERIOD_NS;
    localparam int PW_SEL00_CYC = PW_SEL00_NS / CLK_PERIOD_NS;
    localparam int PW_SEL01_CYC = PW_SEL01_NS / CLK_PERIOD_NS;
    localparam int PW_SEL10_CYC = PW_SEL10_NS / CLK_PERIOD_NS;
    localparam int PW_SEL11_CYC = PW_SEL11_NS / CLK_PERIOD_NS;
    localparam int EDGE_DELAY_CYC = (EDGE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int DIV8_MASK = 7;
    localparam int DIV128_MASK = 127;

endpackage : mrs_pkg
`default_nettype wire

// File: dv/mrs_sampler_properties.sv
`default_nettype none
module mrs_sampler_properties
#(
    parameter int PW_LONG_CYC = 20
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire mrs_pkg::mrs_axi_req_t s_axi_req,
    input wire mrs_pkg::mrs_axi_rsp_t s_axi_rsp,
    input wire logic sample_clock_out_a,
    input wire logic sample_clock_out_a_oe,
    input wire logic sample_clock_out_b,
    input wire logic sample_clock_out_b_oe,
    input wire logic compare_match_irq,
    input wire logic edge_detect_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    import mrs_pkg::*;
    logic run_ff, mode_ff;
    logic [1:0] pw_ff, en_ff;
    logic [7:0] rd_ofs_ff;
    logic [15:0] hi_cnt_ff;
    wire logic wr_take = s_axi_req.awvalid && s_axi_rsp.awready && s_axi_req.wvalid
        && s_axi_rsp.wready;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // shadow copies of run, mode, width and enable bits taken at the write handshake
    always_ff @(posedge aclk)
    begin
        hi_cnt_ff <= sample_clock_out_a ? hi_cnt_ff + 16'h1 : 16'h0;
        if (s_axi_req.arvalid && s_axi_rsp.arready)
            rd_ofs_ff <= s_axi_req.araddr;
        if (!aresetn)
            {run_ff, mode_ff, pw_ff, en_ff} <= 6'h00;
        else if (wr_take && s_axi_req.awaddr == OFS_COUNTER_CTRL)
            {run_ff, mode_ff} <= s_axi_req.wdata[7:6];
        else if (wr_take && s_axi_req.awaddr == OFS_SAMPLING_CTRL)
            {pw_ff, en_ff} <= s_axi_req.wdata[3:0];
    end
    bresp_hold_a: assert property (
        s_axi_rsp.bvalid && !s_axi_req.bready |=> s_axi_rsp.bvalid && $stable(s_axi_rsp.bresp))
        else $error("write response dropped early");
    match_pulse_a: assert property (
        $rose(compare_match_irq) |=> !compare_match_irq) else $error("match pulse too long");
    timer_toggle_a: assert property (
        compare_match_irq && !mode_ff |-> sample_clock_out_a != $past(sample_clock_out_a, 2)
        && sample_clock_out_b != $past(sample_clock_out_b, 2)) else $error("no toggle on match");
    toggle_cause_a: assert property (
        run_ff && !mode_ff && $changed(sample_clock_out_a) |-> ##[0:2] compare_match_irq)
        else $error("timer output moved without a match");
    flags_clear_a: assert property (
        s_axi_rsp.rvalid && rd_ofs_ff == OFS_SAMPLING_CTRL && !mode_ff
        |-> s_axi_rsp.rdata[7:5] == 3'h0) else $error("status flags set in timer mode");
    edge_mode_a: assert property (
        edge_detect_irq |-> mode_ff ##1 !edge_detect_irq) else $error("edge event misplaced");
    pulse_width_a: assert property (
        $fell(sample_clock_out_a) && mode_ff && pw_ff == 2'h1 |-> hi_cnt_ff == PW_LONG_CYC)
        else $error("sampling pulse width wrong");
    pin_enable_a: assert property (
        not (({sample_clock_out_b_oe, sample_clock_out_a_oe} != en_ff) [*4]))
        else $error("pin enable does not follow its bit");
endmodule : mrs_sampler_properties
bind mrs_sampler mrs_sampler_properties #(.PW_LONG_CYC(PW_LONG_CYC)) u_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_req(s_axi_req), .s_axi_rsp(s_axi_rsp),
    .sample_clock_out_a(sample_clock_out_a), .sample_clock_out_a_oe(sample_clock_out_a_oe),
    .sample_clock_out_b(sample_clock_out_b), .sample_clock_out_b_oe(sample_clock_out_b_oe),
    .compare_match_irq(compare_match_irq), .edge_detect_irq(edge_detect_irq)
);
`default_nettype wire

// File: dv/mrs_sensor_model.sv
`default_nettype none
module mrs_sensor_model
(
    input wire logic aclk,
    input wire logic excite_a,
    input wire logic excite_b,
    input wire logic level_a,
    input wire logic level_b,
    output logic sense_a,
    output logic sense_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] hold_a_ff, hold_b_ff;
    initial {sense_a, sense_b, hold_a_ff, hold_b_ff} = 6'h00;
    // valid only while excited and shortly after; otherwise the outputs wander
    always @(posedge aclk)
    begin
        hold_a_ff <= excite_a ? 2'h3 : hold_a_ff - {1'b0, hold_a_ff != 2'h0};
        hold_b_ff <= excite_b ? 2'h3 : hold_b_ff - {1'b0, hold_b_ff != 2'h0};
        sense_a <= (excite_a || hold_a_ff != 2'h0) ? level_a : !sense_a;
        sense_b <= (excite_b || hold_b_ff != 2'h0) ? level_b : !sense_b;
    end
endmodule : mrs_sensor_model
`default_nettype wire

// File: dv/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import mrs_pkg::*;
    localparam int PW_TEST = 20;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic lvl_a = 1'b0;
    logic lvl_b = 1'b0;
    logic sin_a, sin_b, out_a, oe_a, out_b, oe_b, cm_irq, ed_irq;
    mrs_axi_req_t req = '0;
    mrs_axi_rsp_t rsp;
    int err_count = 0;
    int total_checks = 0;
    always #50 aclk = ~aclk;
    mrs_sampler #(.PW_LONG_CYC(PW_TEST)) DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp),
        .sensor_input_a(sin_a), .sensor_input_b(sin_b),
        .sample_clock_out_a(out_a), .sample_clock_out_a_oe(oe_a),
        .sample_clock_out_b(out_b), .sample_clock_out_b_oe(oe_b),
        .compare_match_irq(cm_irq), .edge_detect_irq(ed_irq)
    );
    mrs_sensor_model sensor (
        .aclk(aclk), .excite_a(out_a && oe_a), .excite_b(out_b && oe_b),
        .level_a(lvl_a), .level_b(lvl_b), .sense_a(sin_a), .sense_b(sin_b)
    );
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    task automatic timeout();
        $display("MISMATCH at %0t: wait timed out", $time);
        err_count++;
        wrap_up();
    endtask : timeout
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH at %0t: %s got %0h exp %0h", $time, what, got, exp);
            err_count++;
        end
    endtask : chk
    // 0 match, 1 edge event, 2 falling and 3 rising sampling clock
    task automatic wait_ev(input int which, output int n);
        logic prev, hit;
        n = 0;
        prev = out_a;
        do
        begin
            @(posedge aclk);
            n++;
            hit = which == 0 ? cm_irq : which == 1 ? ed_irq : which == 2 ? prev && !out_a
                : !prev && out_a;
            prev = out_a;
        end
        while (hit !== 1'b1 && n < 8000);
        if (hit !== 1'b1)
            timeout();
    endtask : wait_ev
    task automatic axi(input logic wr, input logic [7:0] addr, input logic [7:0] data,
        input logic [1:0] resp);
        int n;
        n = 0;
        req.awaddr <= addr;
        req.araddr <= addr;
        req.wdata <= {24'h000000, data};
        req.wstrb <= 4'hF;
        {req.awvalid, req.wvalid, req.bready} <= {3{wr}};
        {req.arvalid, req.rready} <= {2{!wr}};
        do
        begin
            @(posedge aclk);
            n++;
            req.awvalid <= req.awvalid && rsp.awready !== 1'b1;
            req.wvalid <= req.wvalid && rsp.wready !== 1'b1;
            req.arvalid <= req.arvalid && rsp.arready !== 1'b1;
        end
        while ((wr ? rsp.bvalid : rsp.rvalid) !== 1'b1 && n < 200);
        {req.bready, req.rready} <= 2'h0;
        if ((wr ? rsp.bvalid : rsp.rvalid) !== 1'b1)
            timeout();
        chk(wr ? rsp.bresp : rsp.rresp, resp, "response");
        if (!wr && resp == RESP_OKAY)
            chk(rsp.rdata, {24'h000000, data}, "read data");
        @(posedge aclk);
    endtask : axi
    task automatic s_registers();
        axi(1'b0, OFS_SAMPLING_CTRL, SAMPLING_CTRL_RESET, RESP_OKAY);
        axi(1'b0, OFS_COUNTER_CTRL, COUNTER_CTRL_RESET, RESP_OKAY);
        axi(1'b0, OFS_COMPARE, COMPARE_RESET, RESP_OKAY);
        axi(1'b0, OFS_COUNTER, 8'h00, RESP_OKAY);
        axi(1'b0, 8'h10, 8'h00, RESP_SLVERR);
        axi(1'b1, 8'h10, 8'h5A, RESP_SLVERR);
        axi(1'b1, OFS_SAMPLING_CTRL, 8'hFE, RESP_OKAY);
        axi(1'b0, OFS_SAMPLING_CTRL, 8'h0E, RESP_OKAY);
        chk({oe_b, oe_a}, 2'h2, "pin enables");
        axi(1'b1, OFS_SAMPLING_CTRL, 8'h03, RESP_OKAY);
        chk({oe_b, oe_a}, 2'h3, "pin enables");
    endtask : s_registers
    // the match period is compare + 1 ticks of the selected count clock
    task automatic s_timer(input logic [7:0] ctrl, input logic [7:0] cmp, input int period);
        int n;
        logic pa, pb;
        axi(1'b1, OFS_COMPARE, cmp, RESP_OKAY);
        axi(1'b1, OFS_COUNTER_CTRL, ctrl, RESP_OKAY);
        axi(1'b0, OFS_COUNTER_CTRL, ctrl, RESP_OKAY);
        wait_ev(0, n);
        pa = out_a;
        pb = out_b;
        wait_ev(0, n);
        chk(n, period, "timer period");
        chk({out_b, out_a}, {~pb, ~pa}, "timer toggle");
        axi(1'b1, OFS_COUNTER_CTRL, 8'h00, RESP_OKAY);
    endtask : s_timer
    // input a settles one sample ahead of input b so the two edges never overlap
    task automatic phase_step(input logic a, input logic b, input logic [7:0] exp);
        int n;
        lvl_a <= a;
        wait_ev(2, n);
        lvl_b <= b;
        wait_ev(2, n);
        wait_ev(1, n);
        chk(n >= EDGE_DELAY_CYC - 1 && n <= EDGE_DELAY_CYC + 2, 1'b1, "edge delay");
        axi(1'b0, OFS_SAMPLING_CTRL, exp, RESP_OKAY);
    endtask : phase_step
    task automatic s_sampling();
        int n;
        axi(1'b1, OFS_COMPARE, 8'h01, RESP_OKAY);
        axi(1'b1, OFS_SAMPLING_CTRL, 8'h07, RESP_OKAY);
        axi(1'b1, OFS_COUNTER_CTRL, 8'hC0, RESP_OKAY);
        wait_ev(3, n);
        wait_ev(2, n);
        chk(n, PW_TEST, "pulse width");
        phase_step(1'b1, 1'b1, 8'hC7);
        phase_step(1'b0, 1'b0, 8'h07);
        phase_step(1'b0, 1'b1, 8'hA7);
        phase_step(1'b1, 1'b0, 8'h67);
        axi(1'b1, OFS_COUNTER_CTRL, 8'h00, RESP_OKAY);
        axi(1'b0, OFS_SAMPLING_CTRL, 8'h07, RESP_OKAY);
    endtask : s_sampling
    // one sampling pulse with the given width select, counter stopped afterwards
    task automatic pw_step(input logic [7:0] samp, input int exp);
        int n;
        axi(1'b1, OFS_SAMPLING_CTRL, samp, RESP_OKAY);
        axi(1'b1, OFS_COUNTER_CTRL, 8'hC0, RESP_OKAY);
        wait_ev(3, n);
        wait_ev(2, n);
        chk(n, exp, "pulse width");
        axi(1'b1, OFS_COUNTER_CTRL, 8'h00, RESP_OKAY);
    endtask : pw_step
    // compare 2 keeps the longest width below the match period
    task automatic s_widths();
        axi(1'b1, OFS_COMPARE, 8'h02, RESP_OKAY);
        pw_step(8'h03, PW_SEL00_CYC);
        pw_step(8'h0B, PW_SEL10_CYC);
        pw_step(8'h0F, PW_SEL11_CYC);
    endtask : s_widths
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        s_registers();
        s_timer(8'h83, 8'h02, 3 * SUB_CLK2_CYC);
        s_timer(8'h81, 8'h01, 2 * (DIV8_MASK + 1) * SUB_CLK1_CYC);
        s_sampling();
        s_widths();
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
